// *** src/spc_map.svh ***
// Register map, field positions, reset values and timing counts
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define SPC_OFF_CTRL 8'h00
`define SPC_OFF_LINE 8'h04
`define SPC_OFF_MASK 8'h08
`define SPC_OFF_STAT 8'h0c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SPC_CTRL_IGNORE_BIT 0
`define SPC_CTRL_RESTORE_BIT 1
`define SPC_LINE_BAUD_LSB 0
`define SPC_LINE_BAUD_MSB 2
`define SPC_LINE_PAR_LSB 4
`define SPC_LINE_PAR_MSB 5
`define SPC_LINE_DATA8_BIT 8
`define SPC_LINE_STOP2_BIT 12
`define SPC_STAT_WORD_MSB 15
`define SPC_STAT_ERR_BIT 15
`define SPC_STAT_CMPL_BIT 8
`define SPC_STAT_SCODE_LSB 16
`define SPC_STAT_SCODE_MSB 18
`define SPC_STAT_BCODE_LSB 24
`define SPC_STAT_BCODE_MSB 28
`define SPC_MASK_FULL_BIT 1
`define SPC_MASK_BERR_BIT 2
`define SPC_MASK_SERIAL_SIDE_ERROR_COND_BIT 3
`define SPC_MASK_NEMPTY_BIT 4
`define SPC_MASK_EOS_BIT 5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SPC_RST_IGNORE 1'b1
`define SPC_RST_BAUD 3'h5
`define SPC_RST_DATA8 1'b1
`define SPC_RST_STOP2 1'b0
`define SPC_RST_MASK 8'h00

// ----------------------------------------------------------------------
// Baud timing
// ----------------------------------------------------------------------
`define SPC_CLK_HZ 250000000
`define SPC_BAUD_300 300
`define SPC_BAUD_600 600
`define SPC_BAUD_1200 1200
`define SPC_BAUD_2400 2400
`define SPC_BAUD_4800 4800
`define SPC_BAUD_9600 9600
`define SPC_BAUD_19200 19200
`define SPC_BAUD_38400 38400
`define SPC_DIV_W 20

`endif

// *** src/spc_pkg.sv ***
// Types shared by the serial port configuration block
`default_nettype none
package spc_pkg;

	// Parity selection as written to the line register
	typedef enum logic [1:0] {
		SPC_PAR_NONE = 2'h0,
		SPC_PAR_EVEN = 2'h1,
		SPC_PAR_ODD = 2'h2
	} spc_parity_e;

	// Serial fault code as reported in status
	typedef enum logic [2:0] {
		no_serial_fault_code = 3'h0,
		parity_fault_code = 3'h1,
		overrun_fault_code = 3'h2,
		buffer_overflow_code = 3'h3,
		framing_fault_code = 3'h4
	} spc_fault_e;

	typedef logic [4:0] spc_bus_code_t;

endpackage
`default_nettype wire

// *** src/spc_serial_cfg.sv ***
// Serial line configuration, error filtering and service request logic
//
// The APB register port and the register addresses were left to the implementer.
`include "spc_map.svh"
`default_nettype none
module spc_serial_cfg
	import spc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_parity_err,
	input wire logic rx_overrun_err,
	input wire logic rx_framing_err,
	input wire logic rx_buf_full,
	input wire logic rx_buf_nonempty,
	input wire logic eos_seen,
	input wire logic talk_addressed,
	input wire logic bus_err_valid,
	input wire logic [4:0] bus_err_code,
	input wire logic op_complete,
	output logic buf_wr_valid,
	output logic [7:0] buf_wr_data,
	output logic [`SPC_DIV_W-1:0] baud_div,
	output logic [1:0] parity_mode,
	output logic data_bits_eight,
	output logic two_stop_bits,
	output logic srq
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic ignore_reg;
	logic ignore_next;
	logic [2:0] baud_reg;
	logic [2:0] baud_next;
	spc_parity_e parity_reg;
	spc_parity_e parity_next;
	logic data8_reg;
	logic data8_next;
	logic stop2_reg;
	logic stop2_next;
	logic [7:0] mask_reg;
	logic [7:0] mask_next;
	spc_fault_e scode_reg;
	spc_fault_e scode_next;
	spc_bus_code_t bcode_reg;
	spc_bus_code_t bcode_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic wr_valid_reg;
	logic [7:0] wr_data_reg;
	logic [`SPC_DIV_W-1:0] div_reg;
	logic [`SPC_DIV_W-1:0] div_next;
	logic srq_reg;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	wire logic sel_ctrl = (paddr == `SPC_OFF_CTRL);
	wire logic sel_line = (paddr == `SPC_OFF_LINE);
	wire logic sel_mask = (paddr == `SPC_OFF_MASK);
	wire logic sel_stat = (paddr == `SPC_OFF_STAT);
	wire logic mapped = sel_ctrl | sel_line | sel_mask | sel_stat;
	wire logic access = psel & penable;
	wire logic wr_ok = access & pwrite & mapped;
	wire logic rd_setup = psel & ~penable & ~pwrite;
	// Status read in the access phase counts as a report
	wire logic stat_reported = access & ~pwrite & sel_stat;
	wire logic restore = wr_ok & sel_ctrl & pwdata[`SPC_CTRL_RESTORE_BIT];

	// ------------------------------------------------------------------
	// Settings
	// ------------------------------------------------------------------
	wire logic [1:0] wr_par = pwdata[`SPC_LINE_PAR_MSB:`SPC_LINE_PAR_LSB];
	// Unused parity code keeps the previous choice
	wire logic par_legal = (wr_par != 2'h3);

	always_comb begin
		ignore_next = ignore_reg;
		baud_next = baud_reg;
		parity_next = parity_reg;
		data8_next = data8_reg;
		stop2_next = stop2_reg;
		mask_next = mask_reg;
		if (restore) begin
			ignore_next = `SPC_RST_IGNORE;
			baud_next = `SPC_RST_BAUD;
			parity_next = SPC_PAR_NONE;
			data8_next = `SPC_RST_DATA8;
			stop2_next = `SPC_RST_STOP2;
			mask_next = `SPC_RST_MASK;
		end else if (wr_ok) begin
			if (sel_ctrl) begin
				ignore_next = pwdata[`SPC_CTRL_IGNORE_BIT];
			end
			if (sel_line) begin
				baud_next = pwdata[`SPC_LINE_BAUD_MSB:`SPC_LINE_BAUD_LSB];
				if (par_legal) begin
					parity_next = spc_parity_e'(wr_par);
				end
				data8_next = pwdata[`SPC_LINE_DATA8_BIT];
				stop2_next = pwdata[`SPC_LINE_STOP2_BIT];
			end
			if (sel_mask) begin
				mask_next = pwdata[7:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Baud divisor
	// ------------------------------------------------------------------
	always_comb begin
		div_next = `SPC_DIV_W'(`SPC_CLK_HZ / `SPC_BAUD_9600);
		case (baud_next)
			3'h0: div_next = `SPC_DIV_W'(`SPC_CLK_HZ / `SPC_BAUD_300);
			3'h1: div_next = `SPC_DIV_W'(`SPC_CLK_HZ / `SPC_BAUD_600);
			3'h2: div_next = `SPC_DIV_W'(`SPC_CLK_HZ / `SPC_BAUD_1200);
			3'h3: div_next = `SPC_DIV_W'(`SPC_CLK_HZ / `SPC_BAUD_2400);
			3'h4: div_next = `SPC_DIV_W'(`SPC_CLK_HZ / `SPC_BAUD_4800);
			3'h5: div_next = `SPC_DIV_W'(`SPC_CLK_HZ / `SPC_BAUD_9600);
			3'h6: div_next = `SPC_DIV_W'(`SPC_CLK_HZ / `SPC_BAUD_19200);
			default: div_next = `SPC_DIV_W'(`SPC_CLK_HZ / `SPC_BAUD_38400);
		endcase
	end

	// ------------------------------------------------------------------
	// Receive error filter
	// ------------------------------------------------------------------
	// Overflow: a byte arrives while the buffer has no room
	wire logic rx_overflow = rx_valid & rx_buf_full;
	wire logic rx_err = rx_valid & (rx_parity_err | rx_overrun_err |
		rx_framing_err | rx_buf_full);
	// One code per byte; parity first, framing last
	wire spc_fault_e rx_code = rx_parity_err ? parity_fault_code :
		rx_overrun_err ? overrun_fault_code :
		rx_overflow ? buffer_overflow_code :
		rx_framing_err ? framing_fault_code :
		no_serial_fault_code;
	wire logic rx_store = rx_valid & (ignore_reg | ~rx_err);
	wire logic serial_side_error_cond_set = rx_err & ~ignore_reg;

	// A new error beats a clear in the same cycle
	always_comb begin
		scode_next = scode_reg;
		bcode_next = bcode_reg;
		if (serial_side_error_cond_set) begin
			scode_next = rx_code;
		end else if (stat_reported) begin
			scode_next = no_serial_fault_code;
		end
		if (bus_err_valid) begin
			bcode_next = bus_err_code;
		end else if (stat_reported) begin
			bcode_next = '0;
		end
	end

	// ------------------------------------------------------------------
	// Status and service request
	// ------------------------------------------------------------------
	wire logic serial_side_error_cond_cond = (scode_reg != no_serial_fault_code);
	wire logic berr_cond = (bcode_reg != '0);
	wire logic [15:0] stat_word = {serial_side_error_cond_cond | berr_cond, 6'h00,
		op_complete, 8'h00};
	wire logic not_talk = ~talk_addressed;
	wire logic [7:0] req_cond = {2'b00,
		eos_seen & not_talk,
		rx_buf_nonempty & not_talk,
		serial_side_error_cond_cond,
		berr_cond,
		rx_buf_full & not_talk,
		1'b0};
	// Zero mask gives no request at all
	wire logic srq_next = |(mask_reg & req_cond);

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	wire logic [31:0] rd_ctrl = {31'h0, ignore_reg};
	wire logic [31:0] rd_line = {19'h0, stop2_reg, 3'h0, data8_reg, 2'h0,
		parity_reg, 1'b0, baud_reg};
	wire logic [31:0] rd_mask = {24'h0, mask_reg};
	wire logic [31:0] rd_stat = {3'h0, bcode_reg, 5'h00, scode_reg,
		stat_word};
	wire logic [31:0] rd_mux = sel_ctrl ? rd_ctrl : sel_line ? rd_line :
		sel_mask ? rd_mask : sel_stat ? rd_stat : 32'h0;

	always_comb begin
		prdata_next = prdata_reg;
		if (rd_setup) begin
			prdata_next = rd_mux;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ignore_reg <= `SPC_RST_IGNORE;
			baud_reg <= `SPC_RST_BAUD;
			parity_reg <= SPC_PAR_NONE;
			data8_reg <= `SPC_RST_DATA8;
			stop2_reg <= `SPC_RST_STOP2;
			mask_reg <= `SPC_RST_MASK;
			div_reg <= `SPC_DIV_W'(`SPC_CLK_HZ / `SPC_BAUD_9600);
		end else begin
			ignore_reg <= ignore_next;
			baud_reg <= baud_next;
			parity_reg <= parity_next;
			data8_reg <= data8_next;
			stop2_reg <= stop2_next;
			mask_reg <= mask_next;
			div_reg <= div_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			scode_reg <= no_serial_fault_code;
			bcode_reg <= '0;
			srq_reg <= 1'b0;
			prdata_reg <= 32'h0;
			wr_valid_reg <= 1'b0;
			wr_data_reg <= 8'h00;
		end else begin
			scode_reg <= scode_next;
			bcode_reg <= bcode_next;
			srq_reg <= srq_next;
			prdata_reg <= prdata_next;
			wr_valid_reg <= rx_store;
			wr_data_reg <= rx_valid ? rx_data : wr_data_reg;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign buf_wr_valid = wr_valid_reg;
	assign buf_wr_data = wr_data_reg;
	assign baud_div = div_reg;
	assign parity_mode = parity_reg;
	assign data_bits_eight = data8_reg;
	assign two_stop_bits = stop2_reg;
	assign srq = srq_reg;

endmodule
`default_nettype wire

// *** test/spc_rx_model.sv ***
// Serial receiver model: byte arrivals with fault flags
`default_nettype none
module spc_rx_model (
	input wire logic core_clk,
	input wire logic full_lvl,
	output var logic rx_valid,
	output var logic [7:0] rx_data,
	output var logic rx_parity_err,
	output var logic rx_overrun_err,
	output var logic rx_framing_err,
	output wire logic rx_buf_full
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ovf_reg = 1'b0;
	assign rx_buf_full = full_lvl | ovf_reg;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		{rx_framing_err, rx_overrun_err, rx_parity_err} = 3'h0;
	end
	task automatic send(input logic [7:0] d, input logic [3:0] f);
		@(posedge core_clk);
		rx_valid <= 1'b1;
		rx_data <= d;
		{ovf_reg, rx_framing_err, rx_overrun_err, rx_parity_err} <= f;
		@(posedge core_clk);
		rx_valid <= 1'b0;
		// Idle data inverted so a stale byte never looks current
		rx_data <= ~d;
		{ovf_reg, rx_framing_err, rx_overrun_err, rx_parity_err} <= 4'h0;
	endtask
endmodule
`default_nettype wire

// *** test/spc_serial_cfg_properties.sv ***
// Port assertions for the serial configuration block
`include "spc_map.svh"
`default_nettype none
module spc_serial_cfg_properties (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_parity_err,
	input wire logic rx_overrun_err,
	input wire logic rx_framing_err,
	input wire logic rx_buf_full,
	input wire logic rx_buf_nonempty,
	input wire logic eos_seen,
	input wire logic talk_addressed,
	input wire logic buf_wr_valid,
	input wire logic [7:0] buf_wr_data,
	input wire logic [`SPC_DIV_W-1:0] baud_div,
	input wire logic [1:0] parity_mode,
	input wire logic data_bits_eight,
	input wire logic two_stop_bits,
	input wire logic srq
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CLK = 250000000;
	localparam int RATE [8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400};
	logic ign_reg, ign_next;
	logic [7:0] mask_reg, mask_next;
	wire wr = psel & penable & pwrite;
	wire rst_cmd = wr && paddr == 8'h00 && pwdata[1];
	wire bad = rx_parity_err | rx_overrun_err | rx_framing_err | rx_buf_full;
	wire dflt = baud_div == 20'(CLK / 9600) && parity_mode == 2'h0 &&
		data_bits_eight && !two_stop_bits;
	assign ign_next = (wr && paddr == 8'h00) ? |pwdata[1:0] : ign_reg;
	assign mask_next = (wr && paddr == 8'h08) ? pwdata[7:0] :
		rst_cmd ? 8'h00 : mask_reg;
	always_ff @(posedge core_clk) begin
		ign_reg <= reset ? 1'b1 : ign_next;
		mask_reg <= reset ? 8'h00 : mask_next;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	property p_drop; rx_valid && bad && !ign_reg |=> !buf_wr_valid; endproperty
	a_drop: assert property (p_drop) else $error("bad byte stored");
	property p_keep;
		rx_valid && (ign_reg || !bad) |=> buf_wr_valid && buf_wr_data == $past(rx_data);
	endproperty
	a_keep: assert property (p_keep) else $error("byte lost");
	property p_mask0; mask_reg == 8'h00 |=> !srq; endproperty
	a_mask0: assert property (p_mask0) else $error("srq with zero mask");
	property p_srq_buf;
		(mask_reg[1] && rx_buf_full || mask_reg[4] && rx_buf_nonempty) &&
		!talk_addressed |=> srq;
	endproperty
	a_srq_buf: assert property (p_srq_buf) else $error("no srq");
	property p_srq_eos; mask_reg[5] && eos_seen && !talk_addressed |=> srq; endproperty
	a_srq_eos: assert property (p_srq_eos) else $error("no eos srq");
	property p_srq_talk; talk_addressed && mask_reg[3:2] == 2'h0 |=> !srq; endproperty
	a_srq_talk: assert property (p_srq_talk) else $error("srq while talker");
	property p_line;
		wr && paddr == 8'h04 |=> data_bits_eight == $past(pwdata[8]) &&
		two_stop_bits == $past(pwdata[12]) &&
		baud_div == 20'(CLK / RATE[$past(pwdata[2:0])]);
	endproperty
	a_line: assert property (p_line) else $error("line setup");
	property p_par;
		wr && paddr == 8'h04 && pwdata[5:4] != 2'h3 |=> parity_mode == $past(pwdata[5:4]);
	endproperty
	a_par: assert property (p_par) else $error("parity setup");
	property p_rst; $fell(reset) |-> dflt; endproperty
	a_rst: assert property (p_rst) else $error("reset line setup");
	// Request is registered, so the old mask still acts one cycle
	property p_restore; rst_cmd |=> dflt ##1 !srq; endproperty
	a_restore: assert property (p_restore) else $error("restore");
	property p_stat;
		psel && penable && !pwrite && paddr == 8'h0c |->
		prdata[15] == (prdata[18:16] != 3'h0 || prdata[28:24] != 5'h00);
	endproperty
	a_stat: assert property (p_stat) else $error("status error bit");
	c_drop: cover property (rx_valid && bad && !ign_reg);
	c_srq: cover property ($rose(srq));
	c_restore: cover property (rst_cmd);
endmodule
`default_nettype wire

// *** test/test_serial_port_config_and_srq.sv ***
// Self-checking bench for the serial configuration block
`include "spc_map.svh"
`default_nettype none
module test_serial_port_config_and_srq
	import spc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 0, rd, seed = 32'd62;
	logic full_lvl = 0, rx_buf_nonempty = 0, eos_seen = 0, talk_addressed = 0;
	logic bus_err_valid = 0, op_complete = 0, slv_err;
	logic [4:0] bus_err_code = 5'h00;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, rx_valid, rx_parity_err, rx_overrun_err;
	wire logic rx_framing_err, rx_buf_full, buf_wr_valid, data_bits_eight;
	wire logic two_stop_bits, srq;
	wire logic [7:0] rx_data, buf_wr_data;
	wire logic [`SPC_DIV_W-1:0] baud_div;
	wire logic [1:0] parity_mode;
	int error_cnt = 0, num_checks = 0;
	int rate [8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400};
	logic [7:0] exp_q [$];
	always #2 core_clk = ~core_clk;
	spc_serial_cfg u_dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_data, .rx_parity_err,
		.rx_overrun_err, .rx_framing_err, .rx_buf_full, .rx_buf_nonempty,
		.eos_seen, .talk_addressed, .bus_err_valid, .bus_err_code, .op_complete,
		.buf_wr_valid, .buf_wr_data, .baud_div, .parity_mode, .data_bits_eight,
		.two_stop_bits, .srq);
	spc_rx_model u_rx (.core_clk, .full_lvl, .rx_valid, .rx_data,
		.rx_parity_err, .rx_overrun_err, .rx_framing_err, .rx_buf_full);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] stat(input logic [2:0] s, input logic [4:0] b);
		return {3'h0, b, 5'h0, s, |{s, b}, 15'h0};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		rd = prdata;
		slv_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic rx(input logic [7:0] d, input logic [3:0] f, input bit keep);
		if (keep)
			exp_q.push_back(d);
		u_rx.send(d, f);
	endtask
	task automatic settle();
		repeat (2) @(posedge core_clk);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge core_clk)
		if (buf_wr_valid === 1'b1)
			chk(buf_wr_data, exp_q.size() ? exp_q.pop_front() : 9'h100);
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		give_verdict();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		logic [31:0] v;
		logic [2:0] code [4];
		int sbit [3];
		code = '{parity_fault_code, overrun_fault_code, framing_fault_code,
			buffer_overflow_code};
		sbit = '{1, 4, 5};
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		rdchk(8'h00, 32'h1);
		rdchk(8'h04, 32'h105);
		rdchk(8'h08, 32'h0);
		chk(baud_div, 250000000 / 9600);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			v = (rnd() & 32'h1100) | (32'(rnd() % 3) << 4) | i;
			apb(1'b1, 8'h04, v);
			rdchk(8'h04, v);
			chk(baud_div, 250000000 / rate[i]);
			chk({parity_mode, data_bits_eight, two_stop_bits}, {v[5:4], v[8], v[12]});
		end
		// Unused parity code keeps the old choice
		apb(1'b1, 8'h04, 32'h1135);
		rdchk(8'h04, 32'h1105 | (v & 32'h30));
		$display("test line done");
		for (int i = 0; i < 4; i++) rx(8'h40 + i, 4'(1 << i), 1);
		op_complete <= 1'b1;
		rdchk(8'h0c, stat(3'h0, 5'h0) | 32'h100);
		op_complete <= 1'b0;
		apb(1'b1, 8'h00, 32'h0);
		rdchk(8'h00, 32'h0);
		for (int i = 0; i < 4; i++) begin
			rx(8'h50 + i, 4'(1 << i), 0);
			rdchk(8'h0c, stat(code[i], 5'h0));
		end
		rdchk(8'h0c, stat(3'h0, 5'h0));
		rx(8'h5a, 4'h0, 1);
		$display("test errors done");
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, 8'h08, 32'h1 << sbit[i]);
			{eos_seen, rx_buf_nonempty, full_lvl} <= 3'(1 << i);
			settle();
			chk(srq, 1'b1);
			talk_addressed <= 1'b1;
			settle();
			chk(srq, 1'b0);
			apb(1'b1, 8'h08, 32'h0);
			talk_addressed <= 1'b0;
			settle();
			chk(srq, 1'b0);
			{eos_seen, rx_buf_nonempty, full_lvl} <= 3'h0;
		end
		apb(1'b1, 8'h08, 32'h0c);
		bus_err_valid <= 1'b1;
		bus_err_code <= 5'h11;
		@(posedge core_clk);
		bus_err_valid <= 1'b0;
		settle();
		chk(srq, 1'b1);
		rdchk(8'h0c, stat(3'h0, 5'h11));
		settle();
		chk(srq, 1'b0);
		rx(8'h66, 4'h1, 0);
		settle();
		chk(srq, 1'b1);
		$display("test srq done");
		apb(1'b1, 8'h00, 32'h2);
		rdchk(8'h00, 32'h1);
		rdchk(8'h04, 32'h105);
		rdchk(8'h08, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(slv_err, 1'b1);
		settle();
		chk(exp_q.size(), 0);
		$display("test restore done");
		give_verdict();
	end
endmodule
bind spc_serial_cfg spc_serial_cfg_properties u_props (.core_clk, .reset,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .rx_valid, .rx_data,
	.rx_parity_err, .rx_overrun_err, .rx_framing_err, .rx_buf_full,
	.rx_buf_nonempty, .eos_seen, .talk_addressed, .buf_wr_valid, .buf_wr_data,
	.baud_div, .parity_mode, .data_bits_eight, .two_stop_bits, .srq);
`default_nettype wire
